// ---- akcr_arg_store.sv ----
/*
  Argument word store: byte-strobed writes, registered read data.
  Assumes the controller issues at most one read and one write per cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module akcr_arg_store #(
  parameter int WORDS = 8,
  parameter int IDX_W = 3
) (
  input wire logic   clk,
  akcr_mem_if.store  mem
);

  logic [31:0] word_ff [WORDS];

  // ----------------------------------------------------------------------
  // Byte lanes are written independently so partial stores keep the rest.
  // ----------------------------------------------------------------------
  // One process owns the whole array, so no word has two drivers.
  always_ff @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (mem.wr_en && mem.wr_strb[b]) begin
        word_ff[mem.wr_idx][8*b +: 8] <= mem.wr_data[8*b +: 8];
      end
    end
  end

  // Registered read port; content is not reset to save flops.
  always_ff @(posedge clk) begin
    if (mem.rd_en) begin
      mem.rd_data <= word_ff[mem.rd_idx];
    end
  end

endmodule

`default_nettype wire

// ---- akcr_kernel_model.sv ----
/* Kernel core model: counts LAT cycles of launch, then pulses done one cycle later.
   Assumes launch stays high until the done pulse. */
`timescale 1ns/100ps
`default_nettype none
module akcr_kernel_model #(
  parameter int LAT = 6
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic launch,
  output logic      done,
  output logic      idle,
  output logic      ready
);
  int cnt_ff;

  // One-cycle done pulse; no count while it stands, so launch can drop.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_b) begin
      cnt_ff <= 0;
    end else if (cnt_ff == LAT) begin
      done   <= 1'b1;
      cnt_ff <= 0;
    end else if (launch && !done) begin
      cnt_ff <= cnt_ff + 1;
    end
  end

  // Idle and ready are live levels.
  assign idle  = (cnt_ff == 0) && !launch;
  assign ready = idle;
endmodule
`default_nettype wire

// ---- akcr_mem_if.sv ----
/*
  Interface between the register bank and its argument store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface akcr_mem_if #(
  parameter int IDX_W = 3
);
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic             rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_data;

  modport ctrl  (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, input rd_data);
  modport store (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, output rd_data);
endinterface

`default_nettype wire

// ---- akcr_pkg.sv ----
/*
  Package of the accelerator kernel control register bank: offsets, field
  positions, reset values, protocol and read-state enumerations.
  Assumes a 12-bit byte address on the control slave port and 32-bit data.
*/
package akcr_pkg;

  // ----------------------------------------------------------------------
  // Address map.
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          ADDR_RANGE   = 4096;
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] GIE_OFS      = 12'h004;
  localparam logic [11:0] IER_OFS      = 12'h008;
  localparam logic [11:0] ISR_OFS      = 12'h00C;
  localparam logic [11:0] ARG_BASE     = 12'h010;
  localparam logic [11:0] SCALAR0_OFS  = 12'h010;
  localparam logic [11:0] PTR0_LO_OFS  = 12'h018;
  localparam logic [11:0] PTR0_HI_OFS  = 12'h01C;
  localparam int          ARG_WORDS    = 8;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int LAUNCH_BIT       = 0;
  localparam int FINISHED_BIT     = 1;
  localparam int QUIESCENT_BIT    = 2;
  localparam int ACCEPT_NEXT_BIT  = 3;
  localparam int CONTINUE_BIT     = 4;
  localparam int AUTO_RESTART_BIT = 7;
  localparam int GIE_BIT          = 0;
  localparam int IER_DONE_BIT     = 0;
  localparam int ISR_DONE_BIT     = 0;

  // ----------------------------------------------------------------------
  // Reset values, widths and bus answers.
  // ----------------------------------------------------------------------
  localparam logic        BIT_RST                    = 1'h0;
  localparam logic [31:0] WORD_RST                   = 32'h0000_0000;
  localparam logic [63:0] PTR_RST                    = 64'h0;
  localparam int          PTR_W                      = 64;
  localparam logic [1:0]  RESP_OKAY                  = 2'h0;
  localparam logic        NARROW_BURST_METADATA_FLAG = 1'h0;

  // ----------------------------------------------------------------------
  // Enumerations.
  // ----------------------------------------------------------------------
  typedef enum {
    SEQUENTIAL_HANDSHAKE_PROTOCOL,
    PIPELINED_CHAIN_PROTOCOL,
    NO_CONTROL_PROTOCOL
  } akcr_proto_type;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_FETCH,
    RD_RESP
  } akcr_rd_state_type;

endpackage

// ---- akcr_regs.sv ----
/*
  Control and argument register bank of an accelerator kernel, reached by
  the host over an AXI4-Lite slave port, with start/done handshake to the
  kernel core and an active-high interrupt.
  Assumes all kernel-side inputs are synchronous to CORE_CLK and that
  KERNEL_DONE is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module akcr_regs #(
  parameter akcr_pkg::akcr_proto_type PROTOCOL  = akcr_pkg::SEQUENTIAL_HANDSHAKE_PROTOCOL,
  parameter int                       ARG_WORDS = akcr_pkg::ARG_WORDS
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] S_AXI_CONTROL_AWADDR,
  input  wire logic        S_AXI_CONTROL_AWVALID,
  output logic             S_AXI_CONTROL_AWREADY,
  input  wire logic [31:0] S_AXI_CONTROL_WDATA,
  input  wire logic [3:0]  S_AXI_CONTROL_WSTRB,
  input  wire logic        S_AXI_CONTROL_WVALID,
  output logic             S_AXI_CONTROL_WREADY,
  output logic [1:0]       S_AXI_CONTROL_BRESP,
  output logic             S_AXI_CONTROL_BVALID,
  input  wire logic        S_AXI_CONTROL_BREADY,
  input  wire logic [11:0] S_AXI_CONTROL_ARADDR,
  input  wire logic        S_AXI_CONTROL_ARVALID,
  output logic             S_AXI_CONTROL_ARREADY,
  output logic [31:0]      S_AXI_CONTROL_RDATA,
  output logic [1:0]       S_AXI_CONTROL_RRESP,
  output logic             S_AXI_CONTROL_RVALID,
  input  wire logic        S_AXI_CONTROL_RREADY,
  output logic             KERNEL_LAUNCH,
  output logic             KERNEL_CONTINUE,
  input  wire logic        KERNEL_DONE,
  input  wire logic        KERNEL_IDLE,
  input  wire logic        KERNEL_READY,
  output logic [31:0]      KERNEL_SCALAR0,
  output logic [63:0]      KERNEL_PTR0,
  output logic             KERNEL_NARROW_BURST,
  output logic             INTERRUPT
);

  localparam int IDX_W = $clog2(ARG_WORDS);

  // Control registers exist only when a managed protocol is built in.
  localparam logic MANAGED = (PROTOCOL != akcr_pkg::NO_CONTROL_PROTOCOL);
  localparam logic CHAIN   = (PROTOCOL == akcr_pkg::PIPELINED_CHAIN_PROTOCOL);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic                        launch_ff;
  logic                        finished_ff;
  logic                        auto_ff;
  logic                        cont_ff;
  logic                        gie_ff;
  logic                        ier_ff;
  logic                        isr_ff;
  logic                        irq_ff;
  logic                        bvalid_ff;
  logic [31:0]                 rdata_ff;
  logic [11:0]                 rd_addr_ff;
  logic [31:0]                 scalar0_ff;
  logic [63:0]                 ptr0_ff;
  akcr_pkg::akcr_rd_state_type rd_state_ff;
  akcr_pkg::akcr_rd_state_type nxt_rd_state;
  logic [31:0]                 nxt_rdata;

  logic        wr_fire;
  logic        ar_fire;
  logic [11:0] wr_addr;
  logic        wr_ctrl;
  logic        wr_gie;
  logic        wr_ier;
  logic        wr_isr;
  logic        host_launch;
  logic        isr_clear;
  logic        rd_ctrl;
  logic        wr_arg_hit;
  logic        rd_arg_hit;
  logic [11:0] wr_arg_off;
  logic [11:0] rd_arg_off;
  logic [11:0] fetch_arg_off;
  logic        fetch_arg_hit;

  akcr_mem_if #(.IDX_W(IDX_W)) mem ();

  akcr_arg_store #(
    .WORDS (ARG_WORDS),
    .IDX_W (IDX_W)
  ) u_store (
    .clk (CORE_CLK),
    .mem (mem)
  );

  // Merge byte lanes of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Write channel: address and data are taken together, one per response.
  // ----------------------------------------------------------------------
  // Holding both ready lines low while a response waits keeps exactly one
  // write outstanding, at the cost of one idle cycle between writes.
  assign wr_fire               = S_AXI_CONTROL_AWVALID && S_AXI_CONTROL_WVALID
                                 && !bvalid_ff;
  assign S_AXI_CONTROL_AWREADY = wr_fire;
  assign S_AXI_CONTROL_WREADY  = wr_fire;
  assign S_AXI_CONTROL_BVALID  = bvalid_ff;
  assign S_AXI_CONTROL_BRESP   = akcr_pkg::RESP_OKAY;
  // The 12-bit address wraps at the 4096-byte block edge.
  assign wr_addr               = {S_AXI_CONTROL_AWADDR[11:2], 2'h0};

  // Decoding of the fixed control words below the argument area.
  assign wr_ctrl   = MANAGED && wr_fire && (wr_addr == akcr_pkg::CTRL_OFS);
  assign wr_gie    = MANAGED && wr_fire && (wr_addr == akcr_pkg::GIE_OFS);
  assign wr_ier    = MANAGED && wr_fire && (wr_addr == akcr_pkg::IER_OFS);
  assign wr_isr    = MANAGED && wr_fire && (wr_addr == akcr_pkg::ISR_OFS);
  assign host_launch = wr_ctrl && S_AXI_CONTROL_WSTRB[0]
                       && S_AXI_CONTROL_WDATA[akcr_pkg::LAUNCH_BIT];
  assign isr_clear = wr_isr && S_AXI_CONTROL_WSTRB[0]
                     && S_AXI_CONTROL_WDATA[akcr_pkg::ISR_DONE_BIT];

  // Argument words occupy the area from sixteen upward.
  assign wr_arg_off = wr_addr - akcr_pkg::ARG_BASE;
  assign wr_arg_hit = (wr_addr >= akcr_pkg::ARG_BASE)
                      && (wr_arg_off[11:2] < 10'(ARG_WORDS));

  // Write response is held until the host takes it.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      bvalid_ff <= akcr_pkg::BIT_RST;
    end else if (wr_fire) begin
      bvalid_ff <= 1'h1;
    end else if (S_AXI_CONTROL_BREADY) begin
      bvalid_ff <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Control word.
  // ----------------------------------------------------------------------
  // Launch is set by the host and dropped on the done handshake; with auto
  // restart the kernel relaunches itself, and a host set wins over a drop.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      launch_ff <= akcr_pkg::BIT_RST;
    end else if (host_launch) begin
      launch_ff <= 1'h1;
    end else if (KERNEL_DONE && !auto_ff) begin
      launch_ff <= 1'h0;
    end
  end

  // Finished is set by completion and cleared by reading the control word;
  // a completion in the same cycle as that read survives it.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      finished_ff <= akcr_pkg::BIT_RST;
    end else if (KERNEL_DONE) begin
      finished_ff <= 1'h1;
    end else if (rd_ctrl) begin
      finished_ff <= 1'h0;
    end
  end

  // Auto restart is plain read/write; continue is a one-cycle pulse that
  // only the chained mode produces.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      auto_ff <= akcr_pkg::BIT_RST;
      cont_ff <= akcr_pkg::BIT_RST;
    end else begin
      if (wr_ctrl && S_AXI_CONTROL_WSTRB[0]) begin
        auto_ff <= S_AXI_CONTROL_WDATA[akcr_pkg::AUTO_RESTART_BIT];
      end
      cont_ff <= CHAIN && wr_ctrl && S_AXI_CONTROL_WSTRB[0]
                 && S_AXI_CONTROL_WDATA[akcr_pkg::CONTINUE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt registers.
  // ----------------------------------------------------------------------
  // Enables are single bits; the upper bits read as zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      gie_ff <= akcr_pkg::BIT_RST;
      ier_ff <= akcr_pkg::BIT_RST;
    end else begin
      if (wr_gie && S_AXI_CONTROL_WSTRB[0]) begin
        gie_ff <= S_AXI_CONTROL_WDATA[akcr_pkg::GIE_BIT];
      end
      if (wr_ier && S_AXI_CONTROL_WSTRB[0]) begin
        ier_ff <= S_AXI_CONTROL_WDATA[akcr_pkg::IER_DONE_BIT];
      end
    end
  end

  // Completion sets the status when its source is enabled; writing one
  // clears it, and a completion in that same cycle wins.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      isr_ff <= akcr_pkg::BIT_RST;
    end else if (MANAGED && KERNEL_DONE && ier_ff) begin
      isr_ff <= 1'h1;
    end else if (isr_clear) begin
      isr_ff <= 1'h0;
    end
  end

  // The line is registered so it never glitches toward the host.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      irq_ff <= akcr_pkg::BIT_RST;
    end else begin
      irq_ff <= gie_ff && ier_ff && isr_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Argument registers.
  // ----------------------------------------------------------------------
  // Shadow copies feed the kernel directly; the store serves read-back.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      scalar0_ff <= akcr_pkg::WORD_RST;
      ptr0_ff    <= akcr_pkg::PTR_RST;
    end else if (wr_fire) begin
      if (wr_addr == akcr_pkg::SCALAR0_OFS) begin
        scalar0_ff <= merge(scalar0_ff, S_AXI_CONTROL_WDATA, S_AXI_CONTROL_WSTRB);
      end
      if (wr_addr == akcr_pkg::PTR0_LO_OFS) begin
        ptr0_ff[31:0] <= merge(ptr0_ff[31:0], S_AXI_CONTROL_WDATA,
                               S_AXI_CONTROL_WSTRB);
      end
      if (wr_addr == akcr_pkg::PTR0_HI_OFS) begin
        ptr0_ff[63:32] <= merge(ptr0_ff[63:32], S_AXI_CONTROL_WDATA,
                                S_AXI_CONTROL_WSTRB);
      end
    end
  end

  assign mem.wr_en   = wr_fire && wr_arg_hit;
  assign mem.wr_idx  = wr_arg_off[IDX_W+1:2];
  assign mem.wr_data = S_AXI_CONTROL_WDATA;
  assign mem.wr_strb = S_AXI_CONTROL_WSTRB;

  // ----------------------------------------------------------------------
  // Read channel: take address, fetch, then answer.
  // ----------------------------------------------------------------------
  assign S_AXI_CONTROL_ARREADY = (rd_state_ff == akcr_pkg::RD_IDLE);
  assign ar_fire    = S_AXI_CONTROL_ARVALID && S_AXI_CONTROL_ARREADY;
  assign rd_arg_off = {S_AXI_CONTROL_ARADDR[11:2], 2'h0} - akcr_pkg::ARG_BASE;
  assign rd_arg_hit = (S_AXI_CONTROL_ARADDR >= akcr_pkg::ARG_BASE)
                      && (rd_arg_off[11:2] < 10'(ARG_WORDS));
  assign mem.rd_en  = ar_fire && rd_arg_hit;
  assign mem.rd_idx = rd_arg_off[IDX_W+1:2];

  assign fetch_arg_off = rd_addr_ff - akcr_pkg::ARG_BASE;
  assign fetch_arg_hit = (rd_addr_ff >= akcr_pkg::ARG_BASE)
                         && (fetch_arg_off[11:2] < 10'(ARG_WORDS));
  assign rd_ctrl       = MANAGED && (rd_state_ff == akcr_pkg::RD_FETCH)
                         && (rd_addr_ff == akcr_pkg::CTRL_OFS);

  // Read data mux; reserved and unmapped words answer zero.
  always_comb begin
    nxt_rdata = akcr_pkg::WORD_RST;
    if (fetch_arg_hit) begin
      nxt_rdata = mem.rd_data;
    end else if (!MANAGED) begin
      nxt_rdata = akcr_pkg::WORD_RST;
    end else if (rd_addr_ff == akcr_pkg::CTRL_OFS) begin
      nxt_rdata[akcr_pkg::LAUNCH_BIT]       = launch_ff;
      nxt_rdata[akcr_pkg::FINISHED_BIT]     = finished_ff;
      nxt_rdata[akcr_pkg::QUIESCENT_BIT]    = KERNEL_IDLE;
      nxt_rdata[akcr_pkg::ACCEPT_NEXT_BIT]  = KERNEL_READY;
      nxt_rdata[akcr_pkg::AUTO_RESTART_BIT] = auto_ff;
    end else if (rd_addr_ff == akcr_pkg::GIE_OFS) begin
      nxt_rdata[akcr_pkg::GIE_BIT] = gie_ff;
    end else if (rd_addr_ff == akcr_pkg::IER_OFS) begin
      nxt_rdata[akcr_pkg::IER_DONE_BIT] = ier_ff;
    end else if (rd_addr_ff == akcr_pkg::ISR_OFS) begin
      nxt_rdata[akcr_pkg::ISR_DONE_BIT] = isr_ff;
    end else begin
      nxt_rdata = akcr_pkg::WORD_RST;
    end
  end

  // Read sequencer.
  always_comb begin
    nxt_rd_state = rd_state_ff;
    case (rd_state_ff)
      akcr_pkg::RD_IDLE: begin
        if (ar_fire) begin
          nxt_rd_state = akcr_pkg::RD_FETCH;
        end
      end
      akcr_pkg::RD_FETCH: begin
        nxt_rd_state = akcr_pkg::RD_RESP;
      end
      akcr_pkg::RD_RESP: begin
        if (S_AXI_CONTROL_RREADY) begin
          nxt_rd_state = akcr_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_rd_state = akcr_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rd_state_ff <= akcr_pkg::RD_IDLE;
      rd_addr_ff  <= akcr_pkg::CTRL_OFS;
      rdata_ff    <= akcr_pkg::WORD_RST;
    end else begin
      rd_state_ff <= nxt_rd_state;
      if (ar_fire) begin
        rd_addr_ff <= {S_AXI_CONTROL_ARADDR[11:2], 2'h0};
      end
      if (rd_state_ff == akcr_pkg::RD_FETCH) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign S_AXI_CONTROL_RVALID = (rd_state_ff == akcr_pkg::RD_RESP);
  assign S_AXI_CONTROL_RDATA  = rdata_ff;
  assign S_AXI_CONTROL_RRESP  = akcr_pkg::RESP_OKAY;

  // ----------------------------------------------------------------------
  // Kernel side.
  // ----------------------------------------------------------------------
  assign KERNEL_LAUNCH       = launch_ff;
  assign KERNEL_CONTINUE     = cont_ff;
  assign KERNEL_SCALAR0      = scalar0_ff;
  assign KERNEL_PTR0         = ptr0_ff;
  // Advertised to the memory masters: only full-width incrementing bursts.
  assign KERNEL_NARROW_BURST = akcr_pkg::NARROW_BURST_METADATA_FLAG;
  // A single clock and its own reset serve every port here.
  assign INTERRUPT           = irq_ff;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence ar_take_s;
    S_AXI_CONTROL_ARVALID && S_AXI_CONTROL_ARREADY;
  endsequence
  sequence r_answer_s;
    ##2 S_AXI_CONTROL_RVALID;
  endsequence

  read_latency_a: assert property (ar_take_s |-> r_answer_s)
    else $error("read answer not two cycles after address");
  write_resp_a: assert property (wr_fire |=> S_AXI_CONTROL_BVALID && !S_AXI_CONTROL_AWREADY)
    else $error("write response missing after write");
  irq_gate_a: assert property (!(gie_ff && ier_ff) |=> !INTERRUPT)
    else $error("interrupt raised without both enables");
  irq_raise_a: assert property (gie_ff && ier_ff && isr_ff |=> INTERRUPT)
    else $error("interrupt not raised with enables and status");
  done_status_a: assert property (KERNEL_DONE && ier_ff |=> isr_ff)
    else $error("completion did not set interrupt status");
  status_hold_a: assert property (isr_ff && !isr_clear |=> isr_ff)
    else $error("interrupt status dropped without a clear write");
  finished_read_a: assert property (rd_ctrl && !KERNEL_DONE |=> !finished_ff)
    else $error("finished bit not cleared by read");
  launch_write_a: assert property (host_launch |=> launch_ff ##1 (launch_ff || $past(KERNEL_DONE)))
    else $error("launch bit not set by host write");
  reserved_zero_a: assert property (rd_state_ff == akcr_pkg::RD_FETCH && !fetch_arg_hit
                                    && rd_addr_ff > akcr_pkg::ISR_OFS
                                    |=> S_AXI_CONTROL_RDATA == 32'h0000_0000)
    else $error("reserved word did not read zero");

endmodule

`default_nettype wire

// ---- akcr_regs_tb.sv ----
/* Testbench of the kernel control register bank.
   Assumes the kernel model drives the handshake inputs. */
`timescale 1ns/100ps
`default_nettype none
module akcr_regs_tb;
  logic        clk, rst_b, awv, wv, arv, lnch, done, idle, rdy, irq, rv, arr, awr, nb, bv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdq, seed, sc, lo, hi;
  logic [63:0] ptr;
  logic [31:0] expq[$];
  int          num_errors, num_checks, n;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  akcr_kernel_model kern_u (.clk(clk), .rst_b(rst_b), .launch(lnch), .done(done),
    .idle(idle), .ready(rdy));

  akcr_regs dut_u (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_CONTROL_AWADDR(awa),
    .S_AXI_CONTROL_AWVALID(awv), .S_AXI_CONTROL_AWREADY(awr), .S_AXI_CONTROL_WDATA(wd),
    .S_AXI_CONTROL_WSTRB(4'hF), .S_AXI_CONTROL_WVALID(wv), .S_AXI_CONTROL_WREADY(),
    .S_AXI_CONTROL_BRESP(), .S_AXI_CONTROL_BVALID(bv), .S_AXI_CONTROL_BREADY(1'b1),
    .S_AXI_CONTROL_ARADDR(ara), .S_AXI_CONTROL_ARVALID(arv), .S_AXI_CONTROL_ARREADY(arr),
    .S_AXI_CONTROL_RDATA(rdq), .S_AXI_CONTROL_RRESP(), .S_AXI_CONTROL_RVALID(rv),
    .S_AXI_CONTROL_RREADY(1'b1), .KERNEL_LAUNCH(lnch), .KERNEL_CONTINUE(),
    .KERNEL_DONE(done), .KERNEL_IDLE(idle), .KERNEL_READY(rdy), .KERNEL_SCALAR0(sc),
    .KERNEL_PTR0(ptr), .KERNEL_NARROW_BURST(nb), .INTERRUPT(irq));

  // --------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A bound that ran out counts as a mismatch and ends the run.
  task automatic hang();
    if (n >= 64) begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    n = 0;
    // Ready is looked at mid-cycle, where it is settled; the next edge takes it.
    do begin @(negedge clk); n++; end while (awr !== 1'b1 && n < 64);
    hang();
    @(posedge clk);
    awv <= 1'b0;
    wv  <= 1'b0;
    @(negedge clk);
    chk(bv, 1'b1);
    repeat (2) @(posedge clk);
  endtask

  // The expected word is queued; the monitor compares it with the answer.
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (arr !== 1'b1 && n < 64);
    hang();
    @(posedge clk);
    arv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Read answers are taken with ready held high, so valid alone marks one;
  // sampling mid-cycle avoids racing the edge that launches the answer.
  always @(negedge clk)
    if (rv === 1'b1) chk(rdq, expq.pop_front());

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    {rst_b, awv, wv, arv, awa, ara, wd} = '0;
    seed = 32'h0000_413E;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    rd(12'h000, 32'h0000_000C);
    wr(12'h100, xs());
    rd(12'h100, 32'h0);
    lo = xs();
    hi = xs();
    wr(12'h010, 32'h1234_ABCD);
    wr(12'h018, lo);
    wr(12'h01C, hi);
    rd(12'h010, 32'h1234_ABCD);
    rd(12'h01C, hi);
    chk(sc, 32'h1234_ABCD);
    chk(ptr, {hi, lo});
    chk(nb, 1'b0);
    // Once with the global enable on, once off: status sets either way.
    for (int g = 1; g >= 0; g--) begin
      wr(12'h004, g);
      wr(12'h008, 32'h1);
      wr(12'h000, 32'h1);
      chk(lnch, 1'b1);
      n = 0;
      while (lnch !== 1'b0 && n < 64) begin @(posedge clk); n++; end
      hang();
      repeat (3) @(posedge clk);
      chk(irq, g);
      rd(12'h00C, 32'h1);
      rd(12'h000, 32'h0000_000E);
      rd(12'h000, 32'h0000_000C);
      wr(12'h00C, 32'h1);
      rd(12'h00C, 32'h0);
      chk(irq, 1'b0);
    end
    repeat (10) @(posedge clk);
    chk(expq.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
